// *** adc_readout_pkg.sv ***
// shared constants for the serial readout control of a 16-bit converter
// assumes a 10 MHz system clock; the serial link is sampled, not clocked
package adc_readout_pkg;
    localparam int RESULT_BITS = 16;
    localparam int LEAD_ZEROS = 8;
    localparam int FRAME_EDGES = 24;
    localparam int ACQ_EDGES = 6;
    localparam logic [4:0] CNT_ACQ_END = 5'h06;
    localparam logic [4:0] CNT_DATA_START = 5'h08;
    localparam logic [4:0] CNT_FRAME_END = 5'h18;
    localparam logic [4:0] CNT_RESET = 5'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SELECT_HIGH_MIN_TIME_NS = 50;
    // least time rounds up, never below one cycle
    localparam int SELECT_HIGH_MIN_CYC =
        (SELECT_HIGH_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUF_DEPTH = 2;
endpackage

// *** sample_buffer.sv ***
// two-entry buffer with valid/ready on both sides
// assumes both sides on the system clock
`timescale 1ns/1ps
module sample_buffer (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [15:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [15:0] out_data_o
);
    logic [15:0] mem_reg [0:1];
    logic [15:0] mem_next [0:1];
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////
    // next state: entry 0 is the head, data read from a register
    always_comb begin
        push = in_valid_i && (count_reg != 2'h2);
        pop = out_ready_i && (count_reg != 2'h0);
        mem_next[0] = mem_reg[0];
        mem_next[1] = mem_reg[1];
        count_next = count_reg;
        if (pop) begin
            mem_next[0] = mem_reg[1];
        end
        if (push) begin
            if (count_reg == 2'h0 || (count_reg == 2'h1 && pop)) begin
                mem_next[0] = in_data_i;
            end else begin
                mem_next[1] = in_data_i;
            end
        end
        count_next = count_reg + {1'b0, push} - {1'b0, pop};
    end

    // registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_reg[0] <= 16'h0000;
            mem_reg[1] <= 16'h0000;
            count_reg <= 2'h0;
        end else begin
            mem_reg[0] <= mem_next[0];
            mem_reg[1] <= mem_next[1];
            count_reg <= count_next;
        end
    end

    assign in_ready_o = (count_reg != 2'h2);
    assign out_valid_o = (count_reg != 2'h0);
    assign out_data_o = mem_reg[0];
endmodule

// *** adc_serial_readout.sv ***
// serial readout control of a 16-bit successive-approximation converter
// assumes select and serial clock come from an outside master (async)
`timescale 1ns/1ps
module adc_serial_readout (
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    input wire logic CS_B_I,
    input wire logic SCLK_I,
    input wire logic [15:0] SAMPLE_CODE_I,
    output logic DOUT_O,
    output logic DOUT_OE_O,
    output logic POWERED_O,
    output logic TRACK_O,
    output logic CONVERTING_O,
    output logic RESULT_VALID_O,
    input wire logic RESULT_READY_I,
    output logic [15:0] RESULT_O
);
    typedef enum {ST_SHUTDOWN, ST_ACQUIRE, ST_CONVERT, ST_TRAIL} state_t;

    ////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic sclk_meta_reg;
    logic sclk_sync_reg;
    logic sclk_prev_reg;
    logic cs_prev_reg;

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
        end else begin
            cs_meta_reg <= CS_B_I;
            cs_sync_reg <= cs_meta_reg;
            sclk_meta_reg <= SCLK_I;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_prev_reg <= sclk_sync_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    logic sclk_fall;
    logic cs_fall;
    assign sclk_fall = sclk_prev_reg && !sclk_sync_reg;
    assign cs_fall = cs_prev_reg && !cs_sync_reg;

    ////////////////////////////////////////////////////////////////////
    // frame sequencer state
    state_t state_reg;
    state_t state_next;
    logic [4:0] edge_cnt_reg;
    logic [4:0] edge_cnt_next;
    logic [15:0] sample_reg;
    logic [15:0] sample_next;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic dout_reg;
    logic dout_next;
    logic oe_reg;
    logic oe_next;
    logic push;
    logic buf_ready;
    logic buf_valid;
    logic [15:0] buf_data;

    // next values of the sequencer
    always_comb begin
        state_next = state_reg;
        edge_cnt_next = edge_cnt_reg;
        sample_next = sample_reg;
        shift_next = shift_reg;
        dout_next = dout_reg;
        oe_next = oe_reg;
        push = 1'b0;
        if (cs_sync_reg) begin
            // select high aborts or ends the frame, clears the sequencer; buffered results are kept
            state_next = ST_SHUTDOWN;
            edge_cnt_next = adc_readout_pkg::CNT_RESET;
            sample_next = adc_readout_pkg::RESULT_RESET;
            shift_next = adc_readout_pkg::RESULT_RESET;
            dout_next = 1'b0;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                ST_SHUTDOWN: begin
                    if (cs_fall) begin
                        state_next = ST_ACQUIRE;
                        oe_next = 1'b1;
                        dout_next = 1'b0;
                        edge_cnt_next = adc_readout_pkg::CNT_RESET;
                    end
                end
                ST_ACQUIRE: begin
                    if (sclk_fall) begin
                        edge_cnt_next = edge_cnt_reg + 5'h01;
                        if (edge_cnt_reg + 5'h01 ==
                            adc_readout_pkg::CNT_ACQ_END) begin
                            // hold the input code, begin converting
                            sample_next = SAMPLE_CODE_I;
                            state_next = ST_CONVERT;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (sclk_fall) begin
                        edge_cnt_next = edge_cnt_reg + 5'h01;
                        if (edge_cnt_reg + 5'h01 ==
                            adc_readout_pkg::CNT_DATA_START) begin
                            dout_next = sample_reg[15];
                            shift_next = {sample_reg[14:0], 1'b0};
                        end else if (edge_cnt_reg + 5'h01 >
                                     adc_readout_pkg::CNT_DATA_START) begin
                            dout_next = shift_reg[15];
                            shift_next = {shift_reg[14:0], 1'b0};
                        end else begin
                            dout_next = 1'b0;
                        end
                        if (edge_cnt_reg + 5'h01 ==
                            adc_readout_pkg::CNT_FRAME_END) begin
                            state_next = ST_TRAIL;
                            push = buf_ready;
                        end
                    end
                end
                ST_TRAIL: begin
                    if (sclk_fall) begin
                        dout_next = 1'b0;
                    end
                end
                default: begin
                    state_next = ST_SHUTDOWN;
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_reg <= ST_SHUTDOWN;
            edge_cnt_reg <= adc_readout_pkg::CNT_RESET;
            sample_reg <= adc_readout_pkg::RESULT_RESET;
            shift_reg <= adc_readout_pkg::RESULT_RESET;
            dout_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            edge_cnt_reg <= edge_cnt_next;
            sample_reg <= sample_next;
            shift_reg <= shift_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // finished results wait here for the user side
    sample_buffer u_buf (
        .clk_i(CLK_SYS_I),
        .rst_b_i(RST_B_I),
        .in_valid_i(push),
        .in_ready_o(buf_ready),
        .in_data_i(sample_reg),
        .out_valid_o(buf_valid),
        .out_ready_i(RESULT_READY_I && !RESULT_VALID_O),
        .out_data_o(buf_data)
    );

    // output stage; every output from a flip-flop
    logic res_valid_reg;
    logic res_valid_next;
    logic [15:0] res_reg;
    logic [15:0] res_next;

    always_comb begin
        res_valid_next = res_valid_reg;
        res_next = res_reg;
        if (res_valid_reg && RESULT_READY_I) begin
            res_valid_next = 1'b0;
        end
        if (!res_valid_reg && buf_valid && RESULT_READY_I) begin
            res_valid_next = 1'b1;
            res_next = buf_data;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            res_valid_reg <= 1'b0;
            res_reg <= adc_readout_pkg::RESULT_RESET;
            POWERED_O <= 1'b0;
            TRACK_O <= 1'b0;
            CONVERTING_O <= 1'b0;
        end else begin
            res_valid_reg <= res_valid_next;
            res_reg <= res_next;
            POWERED_O <= !cs_sync_reg;
            TRACK_O <= (state_next == ST_ACQUIRE);
            CONVERTING_O <= (state_next == ST_CONVERT);
        end
    end

    assign DOUT_O = dout_reg;
    assign DOUT_OE_O = oe_reg;
    assign RESULT_VALID_O = res_valid_reg;
    assign RESULT_O = res_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_hiz_when_high;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        cs_sync_reg |=> !DOUT_OE_O;
    endproperty
    a_hiz_when_high: assert property (p_hiz_when_high)
        else $error("output driven while select high");

    property p_fall_drives_low;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (cs_fall && state_reg == ST_SHUTDOWN) |=> (DOUT_OE_O && !DOUT_O);
    endproperty
    a_fall_drives_low: assert property (p_fall_drives_low)
        else $error("select fall did not drive low");

    property p_acq_end;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (!cs_sync_reg && state_reg == ST_ACQUIRE && sclk_fall &&
         edge_cnt_reg == adc_readout_pkg::CNT_ACQ_END - 5'h01) |=>
        (state_reg == ST_CONVERT);
    endproperty
    a_acq_end: assert property (p_acq_end)
        else $error("conversion not started at sixth edge");

    property p_msb_first;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (!cs_sync_reg && sclk_fall &&
         edge_cnt_reg == adc_readout_pkg::CNT_DATA_START - 5'h01 &&
         state_reg == ST_CONVERT) |=> (DOUT_O == $past(sample_reg[15]));
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("msb not presented after eighth edge");

    property p_lead_zeros;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (edge_cnt_reg < adc_readout_pkg::CNT_DATA_START) |-> !DOUT_O;
    endproperty
    a_lead_zeros: assert property (p_lead_zeros)
        else $error("leading bit not zero");

    property p_trail_zero;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (state_reg == ST_TRAIL && sclk_fall) |=> !DOUT_O;
    endproperty
    a_trail_zero: assert property (p_trail_zero)
        else $error("trailing bit not zero");

    property p_reset_on_high;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        cs_sync_reg |=> (edge_cnt_reg == adc_readout_pkg::CNT_RESET &&
                         state_reg == ST_SHUTDOWN);
    endproperty
    a_reset_on_high: assert property (p_reset_on_high)
        else $error("select high did not reset");

    property p_abort;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (state_reg == ST_CONVERT && cs_sync_reg) |=> !CONVERTING_O;
    endproperty
    a_abort: assert property (p_abort)
        else $error("conversion not aborted");

    property p_count_clear;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (cs_sync_reg ##1 cs_sync_reg) |->
        edge_cnt_reg == adc_readout_pkg::CNT_RESET;
    endproperty
    a_count_clear: assert property (p_count_clear)
        else $error("edge count not cleared");

    property p_powered;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        !cs_sync_reg |=> POWERED_O;
    endproperty
    a_powered: assert property (p_powered)
        else $error("not powered with select low");

    property p_fall_change_only;
        @(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (!sclk_fall && !cs_fall && !cs_sync_reg) |=> $stable(DOUT_O);
    endproperty
    a_fall_change_only: assert property (p_fall_change_only)
        else $error("output changed away from falling edge");
endmodule

// *** host_master.sv ***
// serial master model: drives select and serial clock, captures data
// assumes the block samples both lines on the system clock
`timescale 1ns/1ps
module host_master (
    input wire logic clk_i,
    input wire logic dout_i,
    input wire logic dout_oe_i,
    output logic cs_b_o,
    output logic sclk_o
);
    int n_fall;
    logic oe_lost;
    logic [31:0] shift_reg;

    ////////////////////////////////////////////////////////////////////////
    // idle: select high, clock parked low outside frames
    initial begin
        cs_b_o = 1'b1;
        sclk_o = 1'b0;
        n_fall = 0;
        oe_lost = 1'b0;
        shift_reg = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // one frame of n pulses, each phase half clocks, then gap clocks high
    task automatic frame(input int n, input int half, input int gap);
        shift_reg = 32'h0000_0000;
        oe_lost = 1'b0;
        n_fall = 0;
        @(posedge clk_i) cs_b_o <= 1'b0;
        repeat (half) @(posedge clk_i);
        // n decides truncation or trailing clocks
        for (int i = 0; i < n; i++) begin
            // equal phases, 400 ns each at the bench rate
            @(posedge clk_i) sclk_o <= 1'b1;
            repeat (half / 2) @(posedge clk_i);
            // data taken in the high phase, long after the falling edge
            if (dout_oe_i !== 1'b1) begin
                oe_lost = 1'b1;
            end
            shift_reg = {shift_reg[30:0], dout_i};
            repeat (half - half / 2 - 1) @(posedge clk_i);
            @(posedge clk_i) sclk_o <= 1'b0;
            n_fall = i + 1;
            repeat (half - 1) @(posedge clk_i);
        end
        @(posedge clk_i) cs_b_o <= 1'b1;
        // select stays high at least three clocks before the next frame
        repeat (gap) @(posedge clk_i);
    endtask
endmodule

// *** tb.sv ***
// self-checking bench for the serial readout control block
// assumes the host model drives select and clock at an 800 ns period
`timescale 1ns/1ps
module tb;
    logic clk_sys, rst_b, result_ready;
    logic [15:0] sample_code, result;
    logic dout, dout_oe, powered, track, converting, result_valid;
    logic cs_b, sclk;
    int failures, n_tests, cycles;
    logic [15:0] got[$];

    ////////////////////////////////////////////////////////////////////////
    // system clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    adc_serial_readout dut (.CLK_SYS_I(clk_sys), .RST_B_I(rst_b),
        .CS_B_I(cs_b), .SCLK_I(sclk), .SAMPLE_CODE_I(sample_code),
        .DOUT_O(dout), .DOUT_OE_O(dout_oe), .POWERED_O(powered),
        .TRACK_O(track), .CONVERTING_O(converting),
        .RESULT_VALID_O(result_valid), .RESULT_READY_I(result_ready),
        .RESULT_O(result));

    host_master host (.clk_i(clk_sys), .dout_i(dout), .dout_oe_i(dout_oe),
        .cs_b_o(cs_b), .sclk_o(sclk));

    ////////////////////////////////////////////////////////////////////////
    // result monitor and hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (result_valid === 1'b1 && result_ready === 1'b1) begin
            got.push_back(result);
        end
        if (cycles == 12000) begin
            failures++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        n_tests++;
        if (act !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // outputs quiet after reset with select high
    task automatic t_idle();
        check(dout_oe, 1'b0);
        check(powered, 1'b0);
        check(result_valid, 1'b0);
        $display("test idle done");
    endtask

    // full frame of n pulses; code changes after capture must not leak
    task automatic t_frame(input logic [15:0] code, input int n);
        got.delete();
        sample_code <= code;
        fork
            host.frame(n, 4, 4);
            begin
                wait (host.n_fall == 3);
                repeat (2) @(posedge clk_sys);
                check({track, converting}, 2'b10);
                check(powered, 1'b1);
                check(dout_oe, 1'b1);
                wait (host.n_fall == 7);
                repeat (2) @(posedge clk_sys);
                check({track, converting}, 2'b01);
                sample_code <= ~code;
            end
        join
        check(host.oe_lost, 1'b0);
        check(host.shift_reg, 32'(code) << (n - 24));
        check(host.shift_reg[n - 1 -: 8], 8'h00);
        repeat (2) @(posedge clk_sys);
        check(dout_oe, 1'b0);
        check(powered, 1'b0);
        repeat (20) @(posedge clk_sys);
        check(32'(got.size()), 32'h1);
        if (got.size() > 0) begin
            check(got[0], code);
        end
        $display("test frame %0d done", n);
    endtask

    // select rises mid-conversion; a fresh frame must then read cleanly
    task automatic t_abort();
        got.delete();
        host.frame(10, 4, 3);
        // outputs drop three clocks after the rise; look once they settled
        @(posedge clk_sys);
        check(dout_oe, 1'b0);
        check(converting, 1'b0);
        repeat (30) @(posedge clk_sys);
        check(32'(got.size()), 32'h0);
        $display("test abort done");
        t_frame(16'h1234, 24);
    endtask

    // receiver stalls over three frames: two kept, the third dropped
    task automatic t_stall();
        got.delete();
        result_ready <= 1'b0;
        sample_code <= 16'h1111;
        host.frame(24, 4, 4);
        sample_code <= 16'h2222;
        host.frame(24, 4, 4);
        sample_code <= 16'h3333;
        host.frame(24, 4, 4);
        repeat (10) @(posedge clk_sys);
        result_ready <= 1'b1;
        repeat (20) @(posedge clk_sys);
        check(32'(got.size()), 32'h2);
        if (got.size() == 2) begin
            check(got[0], 16'h1111);
            check(got[1], 16'h2222);
        end
        $display("test stall done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset for five clocks, then the scenarios
    initial begin
        failures = 0;
        n_tests = 0;
        cycles = 0;
        rst_b = 1'b0;
        result_ready = 1'b1;
        sample_code = 16'h0000;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_idle();
        t_frame(16'hA5C3, 24);
        t_frame(16'hFFFF, 30);
        t_frame(16'h8001, 24);
        t_abort();
        t_stall();
        summarize();
    end
endmodule
